// file: logic/atcc_map.vh
/*
 Register map and field constants of the trigger and calibration control block.
 Assumes inclusion by bare name from logic/ modules.
*/
`ifndef ATCC_MAP_VH
`define ATCC_MAP_VH
`define ATCC_TRIG_BASE      12'h000
`define ATCC_CAL_ADDR       12'h040
`define ATCC_CMP_ADDR       12'h044
`define ATCC_IRQ_STAT_ADDR  12'h048
`define ATCC_IRQ_EN_ADDR    12'h04c
`define ATCC_IRQ_CLR_ADDR   12'h050
`define ATCC_CAL_DONE_BIT   15
`define ATCC_CAL_RSVD_BIT   11
`define ATCC_CAL_DIFF_BIT   10
`define ATCC_CAL_EN_BIT     9
`define ATCC_CAL_START_BIT  8
`define ATCC_CMP_COMPARE_CHANNEL_NUMBER_LSB   8
`define ATCC_CMP_STAT_BIT   5
`define ATCC_CMP_EN_BIT     7
`define ATCC_CMP_WR_MASK    8'hdf
`define ATCC_CMP_CTL_RESET  8'h00
`define ATCC_CAL_RESET      16'h0000
`define ATCC_CMP_RESET      16'h0000
`define ATCC_TRIG_RESET     5'h00
`define ATCC_SRC_NONE       5'h00
`define ATCC_SRC_SW_COMMON  5'h01
`define ATCC_SRC_SW_LEVEL   5'h02
`define ATCC_SRC_PWM_SEV    5'h04
`define ATCC_SRC_PWM_P1     5'h05
`define ATCC_SRC_PWM_P5     5'h09
`define ATCC_SRC_TMR1       5'h0c
`define ATCC_SRC_TMR2       5'h0d
`define ATCC_SRC_PWM_SSEV   5'h0e
`define ATCC_SRC_PWM_S1     5'h0f
`define ATCC_SRC_PWM_S5     5'h13
`define ATCC_SRC_OC1        5'h16
`define ATCC_SRC_OC2        5'h17
`define ATCC_SRC_CL1        5'h18
`define ATCC_SRC_CL5        5'h1c
`define ATCC_SRC_EXT        5'h1f
`define ATCC_CAL_CYCLES     8'd32
`endif

// file: logic/atcc_top.v
/*
 Trigger source decode per analog input, shared core calibration control,
 comparator control layout and interrupt status, all behind an APB slave.
 Assumes event inputs are one-cycle pulses in core_clk domain; the external
 trigger pin is asynchronous and is synchronised here.
 Assumes an APB master; the slave inserts no wait state and registers read
 data at the setup edge, so it stands through the access phase.
*/
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "atcc_map.vh"
module atcc_top #(
  parameter NUM_IN     = 6,
  parameter CAL_CYCLES = 32
) (
  input  wire              core_clk,
  input  wire              reset_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output reg  [31:0]       prdata,
  output wire              pslverr,
  input  wire              sw_common_trig,
  input  wire              sw_level_trig,
  input  wire              pwm_sev_trig,
  input  wire              pwm_ssev_trig,
  input  wire [4:0]        pwm_pri_trig,
  input  wire [4:0]        pwm_sec_trig,
  input  wire [4:0]        pwm_cl_trig,
  input  wire              tmr1_match,
  input  wire              tmr2_match,
  input  wire [1:0]        oc_trig,
  input  wire              external_trigger_input,
  input  wire              cal_core_done,
  output reg               cal_core_start,
  output reg               cal_core_diff,
  input  wire              cmp_event,
  input  wire [4:0]        cmp_event_chan,
  output reg  [NUM_IN-1:0] conv_req,
  output wire              irq
);
  reg  [4:0]        trigger_source_code_r [0:NUM_IN-1];
  reg               cal_done_flag_r;
  reg               cal_differential_select_r;
  reg               cal_access_enable_r;
  reg               cal_start_r;
  reg               cal_busy_r;
  reg  [7:0]        cal_cnt_r;
  reg  [4:0]        compare_channel_number_r;
  reg               cmp_stat_r;
  reg  [7:0]        cmp_ctl_r;
  reg  [2:0]        irq_stat_r;
  reg  [2:0]        irq_en_r;
  reg               ext_s1_r;
  reg               ext_s2_r;
  reg               ext_s3_r;
  wire              wr_en;
  wire              rd_en;
  wire              ext_pulse;
  wire              cal_wr;
  wire              cal_finish;
  wire              start_cal;
  wire [NUM_IN-1:0] conv_nxt;
  wire [2:0]        irq_evt;
  wire              cmp_rd;
  wire [NUM_IN-1:0] trig_hit;
  wire              cal_sel;
  wire              cmp_sel;
  wire              stat_sel;
  wire              en_sel;
  wire              clr_sel;
  reg  [31:0]       rd_mux;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  // Exact word match; unmapped offsets fall through and read zero
  assign cal_sel  = (paddr == `ATCC_CAL_ADDR);
  assign cmp_sel  = (paddr == `ATCC_CMP_ADDR);
  assign stat_sel = (paddr == `ATCC_IRQ_STAT_ADDR);
  assign en_sel   = (paddr == `ATCC_IRQ_EN_ADDR);
  assign clr_sel  = (paddr == `ATCC_IRQ_CLR_ADDR);
  assign cal_wr   = wr_en & cal_sel;
  assign cmp_rd   = rd_en & cmp_sel;

  // Pin is asynchronous; third stage only for edge detect
  always @(posedge core_clk) begin
    if (!reset_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_trigger_input;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_pulse = ext_s2_r & ~ext_s3_r;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_in
      reg sel_hit;
      always @* begin
        sel_hit = 1'b0;
        case (trigger_source_code_r[gi])
          `ATCC_SRC_NONE:      sel_hit = 1'b0;
          `ATCC_SRC_SW_COMMON: sel_hit = sw_common_trig;
          `ATCC_SRC_SW_LEVEL:  sel_hit = sw_level_trig;
          `ATCC_SRC_PWM_SEV:   sel_hit = pwm_sev_trig;
          5'h05:               sel_hit = pwm_pri_trig[0];
          5'h06:               sel_hit = pwm_pri_trig[1];
          5'h07:               sel_hit = pwm_pri_trig[2];
          5'h08:               sel_hit = pwm_pri_trig[3];
          `ATCC_SRC_PWM_P5:    sel_hit = pwm_pri_trig[4];
          `ATCC_SRC_TMR1:      sel_hit = tmr1_match;
          `ATCC_SRC_TMR2:      sel_hit = tmr2_match;
          `ATCC_SRC_PWM_SSEV:  sel_hit = pwm_ssev_trig;
          `ATCC_SRC_PWM_S1:    sel_hit = pwm_sec_trig[0];
          5'h10:               sel_hit = pwm_sec_trig[1];
          5'h11:               sel_hit = pwm_sec_trig[2];
          5'h12:               sel_hit = pwm_sec_trig[3];
          `ATCC_SRC_PWM_S5:    sel_hit = pwm_sec_trig[4];
          `ATCC_SRC_OC1:       sel_hit = oc_trig[0];
          `ATCC_SRC_OC2:       sel_hit = oc_trig[1];
          `ATCC_SRC_CL1:       sel_hit = pwm_cl_trig[0];
          5'h19:               sel_hit = pwm_cl_trig[1];
          5'h1a:               sel_hit = pwm_cl_trig[2];
          5'h1b:               sel_hit = pwm_cl_trig[3];
          `ATCC_SRC_CL5:       sel_hit = pwm_cl_trig[4];
          `ATCC_SRC_EXT:       sel_hit = ext_pulse;
          default:             sel_hit = 1'b0;
        endcase
      end
      localparam [31:0] TRIG_OFS = `ATCC_TRIG_BASE + gi * 4;
      wire [11:0] trig_addr;
      assign trig_addr    = TRIG_OFS[11:0];
      assign trig_hit[gi] = (paddr == trig_addr);
      assign conv_nxt[gi] = sel_hit;
      always @(posedge core_clk) begin
        if (!reset_n) begin
          trigger_source_code_r[gi] <= `ATCC_TRIG_RESET;
        end else if (wr_en && trig_hit[gi]) begin
          trigger_source_code_r[gi] <= pwdata[4:0];
        end
      end
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!reset_n) begin
      conv_req <= {NUM_IN{1'b0}};
    end else begin
      conv_req <= conv_nxt;
    end
  end

  // Internal counter stands in when the core gives no done strobe
  assign cal_finish = cal_busy_r & (cal_core_done | (cal_cnt_r == 8'h01));
  assign start_cal  = cal_wr & pwdata[`ATCC_CAL_EN_BIT] & pwdata[`ATCC_CAL_START_BIT] & ~cal_busy_r;

  always @(posedge core_clk) begin
    if (!reset_n) begin
      cal_done_flag_r           <= 1'b0;
      cal_differential_select_r <= 1'b0;
      cal_access_enable_r       <= 1'b0;
      cal_start_r               <= 1'b0;
      cal_busy_r                <= 1'b0;
    end else begin
      if (cal_wr) begin
        cal_access_enable_r <= pwdata[`ATCC_CAL_EN_BIT];
        if (pwdata[`ATCC_CAL_EN_BIT] && !cal_busy_r) begin
          cal_differential_select_r <= pwdata[`ATCC_CAL_DIFF_BIT];
        end
      end
      if (start_cal) begin
        cal_start_r     <= 1'b1;
        cal_busy_r      <= 1'b1;
        cal_done_flag_r <= 1'b0;
      end else if (cal_finish) begin
        cal_start_r     <= 1'b0;
        cal_busy_r      <= 1'b0;
        cal_done_flag_r <= 1'b1;
      end
    end
  end

  // Countdown only while busy; a longer run needs a wider counter
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cal_cnt_r <= 8'h00;
    end else if (start_cal) begin
      cal_cnt_r <= CAL_CYCLES[7:0];
    end else if (cal_finish) begin
      cal_cnt_r <= 8'h00;
    end else if (cal_busy_r) begin
      cal_cnt_r <= cal_cnt_r - 8'h01;
    end
  end

  // Core sees a one-cycle start and the mode latched with it
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cal_core_start <= 1'b0;
      cal_core_diff  <= 1'b0;
    end else begin
      cal_core_start <= start_cal;
      if (start_cal) begin
        cal_core_diff <= pwdata[`ATCC_CAL_DIFF_BIT];
      end
    end
  end

  // Channel and status follow hardware only; status clears on a read
  always @(posedge core_clk) begin
    if (!reset_n) begin
      compare_channel_number_r <= 5'h00;
      cmp_stat_r               <= 1'b0;
      cmp_ctl_r                <= `ATCC_CMP_CTL_RESET;
    end else begin
      if (wr_en && cmp_sel) begin
        cmp_ctl_r <= pwdata[7:0] & `ATCC_CMP_WR_MASK;
      end
      if (cmp_event && cmp_ctl_r[`ATCC_CMP_EN_BIT]) begin
        compare_channel_number_r <= cmp_event_chan;
        cmp_stat_r               <= 1'b1;
      end else if (cmp_rd || !cmp_ctl_r[`ATCC_CMP_EN_BIT]) begin
        cmp_stat_r <= 1'b0;
      end
    end
  end

  assign irq_evt = {cmp_event & cmp_ctl_r[`ATCC_CMP_EN_BIT], cal_finish, |conv_nxt};
  always @(posedge core_clk) begin
    if (!reset_n) begin
      irq_stat_r <= 3'h0;
      irq_en_r   <= 3'h0;
    end else begin
      if (wr_en && en_sel) begin
        irq_en_r <= pwdata[2:0];
      end
      // Set wins over clear
      if (wr_en && clr_sel) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end
  assign irq = |(irq_stat_r & irq_en_r);

  // Registered at the setup edge; stands through the zero-wait access phase
  always @(posedge core_clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  integer k;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (cal_sel) begin
      // Gated bits read zero while access is disabled; low byte stays zero
      rd_mux[`ATCC_CAL_EN_BIT]    = cal_access_enable_r;
      rd_mux[`ATCC_CAL_DONE_BIT]  = cal_access_enable_r & cal_done_flag_r;
      rd_mux[`ATCC_CAL_DIFF_BIT]  = cal_access_enable_r & cal_differential_select_r;
      rd_mux[`ATCC_CAL_START_BIT] = cal_access_enable_r & cal_start_r;
    end else if (cmp_sel) begin
      rd_mux[7:0]                     = cmp_ctl_r;
      rd_mux[`ATCC_CMP_STAT_BIT]      = cmp_stat_r;
      rd_mux[`ATCC_CMP_COMPARE_CHANNEL_NUMBER_LSB +: 5] = compare_channel_number_r;
    end else if (stat_sel) begin
      rd_mux[2:0] = irq_stat_r;
    end else if (en_sel) begin
      rd_mux[2:0] = irq_en_r;
    end else begin
      for (k = 0; k < NUM_IN; k = k + 1) begin
        if (trig_hit[k]) begin
          rd_mux[4:0] = trigger_source_code_r[k];
        end
      end
    end
  end
endmodule // atcc_top

// file: test/atcc_sva.sv
/* Assertions on the APB and calibration ports of atcc_top.
   Assumes a bind from tb and the register map of atcc_map.vh. */
`timescale 1ns/1ns
`include "atcc_map.vh"
module atcc_sva (
  input logic        core_clk,
  input logic        reset_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        cal_core_start,
  input logic        cal_core_diff
);
  logic acc_cal, rd_cal, go_req, en_r;
  assign acc_cal = psel && penable && paddr == `ATCC_CAL_ADDR;
  assign rd_cal  = acc_cal && !pwrite;
  assign go_req  = acc_cal && pwrite && pwdata[9] && pwdata[8];
  // Shadow of enable bit, so hidden bits can be judged
  always @(posedge core_clk) begin
    if (!reset_n)
      en_r <= 1'b0;
    else if (acc_cal && pwrite)
      en_r <= pwdata[9];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_start_pulse:
    assert property (cal_core_start |=> !cal_core_start) else $error("start pulse too long");
  chk_start_cause:
    assert property ($rose(cal_core_start) |-> $past(go_req)) else $error("start without enabled write");
  chk_diff_latch:
    assert property ($rose(cal_core_start) |-> cal_core_diff == $past(pwdata[10])) else $error("mode not latched");
  chk_diff_hold:
    assert property ($changed(cal_core_diff) |-> $rose(cal_core_start)) else $error("mode moved off start");
  chk_done_busy:
    assert property ($rose(cal_core_start) ##2 rd_cal |-> !prdata[15] && prdata[8]) else $error("busy misread");
  chk_cal_zeros:
    assert property (rd_cal |-> prdata[14:11] == 4'h0 && prdata[7:0] == 8'h00) else $error("unused bits set");
  chk_en_read:
    assert property (rd_cal |-> prdata[9] == en_r) else $error("enable bit misread");
  chk_hidden_bits:
    assert property (rd_cal && !en_r |-> prdata[15:8] == 8'h00) else $error("bits seen while disabled");
  cover property ($rose(cal_core_start));
  cover property (rd_cal && prdata[15]);
  cover property (rd_cal && !en_r);
endmodule // atcc_sva

// file: test/atcc_src_model.sv
/* Event sources around atcc_top: PWM, timers, output compare, pin.
   Assumes fire, fire_all and code change at core_clk rising edges. */
`timescale 1ns/1ns
module atcc_src_model (
  input  logic        core_clk,
  input  logic        fire,
  input  logic        fire_all,
  input  logic [4:0]  code,
  output logic [31:0] ev
);
  // Bit n is the source named by code n; one-cycle pulses like real generators
  initial ev = 32'h0;
  always @(posedge core_clk) begin
    if (fire_all)
      ev <= 32'hffffffff;
    else
      ev <= fire ? 32'h1 << code : 32'h0;
  end
endmodule // atcc_src_model

// file: test/tb.sv
/* Bench of atcc_top: APB registers, calibration, comparator, interrupt, trigger codes.
   Assumes atcc_map.vh on the include path. */
`timescale 1ns/1ns
`include "atcc_map.vh"
module tb;
  localparam NUM_IN = 6;
  logic              core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic              cal_core_done = 1'b0, cmp_event = 1'b0, fire = 1'b0, fire_all = 1'b0;
  logic              pready, pslverr, irq, cal_core_start, cal_core_diff, ok;
  logic [4:0]        code = 5'h00, cmp_event_chan = 5'h00;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata, q, ev;
  logic [NUM_IN-1:0] conv_req, seen;
  int                miscompares = 0, compares = 0;
  always #20 core_clk = ~core_clk;
  atcc_top #(.NUM_IN(NUM_IN), .CAL_CYCLES(16)) dut (
    .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .sw_common_trig(ev[1]), .sw_level_trig(ev[2]), .pwm_sev_trig(ev[4]), .pwm_pri_trig(ev[9:5]),
    .tmr1_match(ev[12]), .tmr2_match(ev[13]), .pwm_ssev_trig(ev[14]), .pwm_sec_trig(ev[19:15]),
    .oc_trig(ev[23:22]), .pwm_cl_trig(ev[28:24]), .external_trigger_input(ev[31]), .cal_core_done,
    .cal_core_start, .cal_core_diff, .cmp_event, .cmp_event_chan, .conv_req, .irq);
  atcc_src_model src (.core_clk, .fire, .fire_all, .code, .ev);
  task automatic end_sim;
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // Idle cycle between transfers keeps each task self-contained
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", 32'h0, 32'(pslverr));
    if (pready !== 1'b1) begin
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      miscompares++;
      end_sim;
    end
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic t_cal;
    rdc("cal reset", `ATCC_CAL_ADDR, 32'h0);
    apb(1'b1, 12'h0fc, 32'hffff);
    rdc("unmapped", 12'h0fc, 32'h0);
    apb(1'b1, `ATCC_CAL_ADDR, 32'h100);
    rdc("start off", `ATCC_CAL_ADDR, 32'h0);
    apb(1'b1, `ATCC_CAL_ADDR, 32'h700);
    @(negedge core_clk);
    chk("core start", 32'h1, 32'(cal_core_start));
    rdc("cal busy", `ATCC_CAL_ADDR, 32'h700);
    chk("diff", 32'h1, 32'(cal_core_diff));
    for (int i = 0; i < 20 && q[8]; i++)
      apb(1'b0, `ATCC_CAL_ADDR, 32'h0);
    chk("cal done", 32'h8600, q);
    rdc("irq status", `ATCC_IRQ_STAT_ADDR, 32'h2);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, `ATCC_IRQ_EN_ADDR, 32'h2);
    @(negedge core_clk);
    chk("irq on", 32'h1, 32'(irq));
    apb(1'b1, `ATCC_IRQ_CLR_ADDR, 32'h2);
    @(negedge core_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b1, `ATCC_CAL_ADDR, 32'h300);
    @(posedge core_clk);
    cal_core_done <= 1'b1;
    chk("diff", 32'h0, 32'(cal_core_diff));
    @(posedge core_clk);
    cal_core_done <= 1'b0;
    rdc("cal early end", `ATCC_CAL_ADDR, 32'h8200);
    apb(1'b1, `ATCC_CAL_ADDR, 32'h0);
    rdc("cal off", `ATCC_CAL_ADDR, 32'h0);
  endtask
  task automatic t_cmp;
    apb(1'b1, `ATCC_CMP_ADDR, 32'hffff);
    rdc("cmp written", `ATCC_CMP_ADDR, 32'h00df);
    @(posedge core_clk);
    cmp_event <= 1'b1;
    cmp_event_chan <= 5'h13;
    @(posedge core_clk);
    cmp_event <= 1'b0;
    rdc("cmp event", `ATCC_CMP_ADDR, 32'h13ff);
    rdc("cmp reread", `ATCC_CMP_ADDR, 32'h13df);
    rdc("irq cmp", `ATCC_IRQ_STAT_ADDR, 32'h6);
  endtask
  // Reserved and zero codes face every source at once
  task automatic t_decode;
    for (int c = 0; c < 32; c++) begin
      ok = !(c inside {0, 3, 10, 11, 20, 21, 29, 30});
      apb(1'b1, `ATCC_TRIG_BASE + 12'(4 * (c % NUM_IN)), 32'(c));
      @(posedge core_clk);
      fire <= ok;
      fire_all <= !ok;
      code <= 5'(c);
      @(posedge core_clk);
      fire <= 1'b0;
      fire_all <= 1'b0;
      seen = '0;
      repeat (8) begin
        @(negedge core_clk);
        seen |= conv_req;
      end
      chk("conv_req", ok ? 32'h1 << (c % NUM_IN) : 32'h0, 32'(seen));
      apb(1'b1, `ATCC_TRIG_BASE + 12'(4 * (c % NUM_IN)), 32'h0);
    end
    rdc("irq conv", `ATCC_IRQ_STAT_ADDR, 32'h7);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_cal;
    t_cmp;
    t_decode;
    end_sim;
  end
endmodule // tb
bind atcc_top atcc_sva u_sva (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .cal_core_start, .cal_core_diff);
